// *** rtl/tmcf_top.sv ***
// Capture registers, flags and interrupt requests of two 16-bit timers on APB
// Assumes counters, compare registers and sequencing live outside, on pclk
//
// Design decision made here: the APB interface to the registers.
`include "tmcf_cfg.svh"
`default_nettype none
module tmcf_top
    import tmcf_pkg::*;
#(
    parameter int ADDR_W = 12, // APB address width
    parameter int FILT_N = `TMCF_FILT_SAMPLES // Equal samples for the noise filter
) (
    input wire logic pclk, // System clock, 200 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped access
    input wire logic [1:0][15:0] timer_count, // Running count, [0] timer_a, [1] timer_b
    input wire logic [1:0] timer_tick, // One pulse per timer clock
    input wire logic [1:0][15:0] compare_a, // Compare register A per timer
    input wire logic [1:0][15:0] compare_b, // Compare register B per timer
    input wire logic [1:0] timer_ovf, // Overflow event from the sequencer
    input wire logic [1:0] capture_input_pin, // Asynchronous capture pins
    input wire logic analog_cmp_out, // Asynchronous analog comparator output
    input wire logic global_irq_en, // Processor global interrupt enable
    input wire logic [1:0][3:0] irq_vector_ack, // Vector taken: cap, cmp b, cmp a, ovf
    output logic [1:0][3:0] irq_request, // Requests: cap, cmp b, cmp a, ovf
    output logic [1:0][15:0] capture_value, // Capture register toward the counter
    output logic [1:0][3:0] waveform_mode_field, // Mode toward the counter
    output logic [1:0] force_cmp_a, // Forced compare A strobe
    output logic [1:0] force_cmp_b // Forced compare B strobe
);
    if (ADDR_W < 12) begin : g_bad_addr
        $error("ADDR_W must be at least 12");
    end

    localparam logic [1:0][9:0] IDX_FLAG = {`TMCF_IDX_FLAG_B, `TMCF_IDX_FLAG_A};
    localparam logic [1:0][9:0] IDX_EN = {`TMCF_IDX_EN_B, `TMCF_IDX_EN_A};
    localparam logic [1:0][9:0] IDX_CTRL = {`TMCF_IDX_CTRL_B, `TMCF_IDX_CTRL_A};
    localparam logic [1:0][9:0] IDX_CAP_LO = {`TMCF_IDX_CAP_LO_B, `TMCF_IDX_CAP_LO_A};
    localparam logic [1:0][9:0] IDX_CAP_HI = {`TMCF_IDX_CAP_HI_B, `TMCF_IDX_CAP_HI_A};

    tmcf_top_t st_reg, st_next;
    logic [9:0] idx;
    logic access;
    logic commit;
    logic wr;
    logic rd;
    logic rd_ok;
    logic [31:0] rd_data;
    logic [1:0] cap_evt;
    logic [1:0] icr_top;
    logic [1:0] top_hit;
    logic [1:0] hit_a;
    logic [1:0] hit_b;
    logic [1:0][7:0] flags_rd;
    logic [1:0][7:0] en_rd;

    // Normal and clear-on-compare modes accept forced compares
    function automatic logic tmcf_non_pwm(input logic [3:0] mode);
        tmcf_non_pwm = (mode == `TMCF_WGM_NORMAL) || (mode == `TMCF_WGM_CTC_A)
            || (mode == `TMCF_WGM_CTC_CAP);
    endfunction : tmcf_non_pwm

    // APB phase decode; a write or read takes effect in the ready cycle
    assign idx = paddr[11:2];
    assign access = psel && penable;
    assign commit = access && (st_reg.apb == ap_done);
    assign wr = commit && pwrite && rd_ok;
    assign rd = commit && !pwrite && rd_ok;

    // Per timer: input conditioning, flag bank and event wiring
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        tmcf_bank_if bank_bus ();

        tmcf_capture_in #(
            .FILT_N(FILT_N)
        ) u_cap (
            .pclk(pclk),
            .presetn(presetn),
            .capture_input_pin(capture_input_pin[i]),
            .analog_cmp_out(analog_cmp_out),
            .use_analog(st_reg.ctrl[i][`TMCF_CTRL_ACMP]),
            .capture_edge_select(st_reg.ctrl[i][`TMCF_CTRL_EDGE]),
            .capture_noise_filter_en(st_reg.ctrl[i][`TMCF_CTRL_FILT]),
            .disable_in(icr_top[i]),
            .capture_evt(cap_evt[i])
        );

        tmcf_flag_bank u_bank (
            .pclk(pclk),
            .presetn(presetn),
            .bus(bank_bus.bank)
        );

        // capture register as top: modes 8, 10, 12 and 14
        assign icr_top[i] = st_reg.ctrl[i][3] && !st_reg.ctrl[i][0];
        // count reaches the capture top value
        assign top_hit[i] = icr_top[i] && timer_tick[i] && (timer_count[i] == st_reg.cap[i]);
        // flag on the tick after the match
        assign hit_a[i] = timer_tick[i] && st_reg.pend_a[i];
        assign hit_b[i] = timer_tick[i] && st_reg.pend_b[i];
        // hardware set events; forced strobes are not among them
        assign bank_bus.set = {(cap_evt[i] && !icr_top[i]) || top_hit[i], hit_b[i], hit_a[i],
                               timer_ovf[i]};
        assign bank_bus.ack = irq_vector_ack[i];
        assign bank_bus.gie = global_irq_en;
        assign bank_bus.wr_flag = wr && (idx == IDX_FLAG[i]);
        assign bank_bus.wr_en = wr && (idx == IDX_EN[i]);
        assign bank_bus.wdata = pwdata[7:0];
        assign flags_rd[i] = bank_bus.flags_rd;
        assign en_rd[i] = bank_bus.en_rd;
        assign irq_request[i] = bank_bus.irq;
        // capture register offered as top value
        assign capture_value[i] = st_reg.cap[i];
        assign waveform_mode_field[i] = st_reg.ctrl[i][3:0];
    end

    // Read multiplexer and address check
    always_comb begin
        rd_data = `TMCF_RD_UNMAPPED;
        rd_ok = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (idx == IDX_FLAG[i]) begin
                rd_data = {24'h0, flags_rd[i]};
                rd_ok = 1'b1;
            end
            if (idx == IDX_EN[i]) begin
                rd_data = {24'h0, en_rd[i]};
                rd_ok = 1'b1;
            end
            if (idx == IDX_CTRL[i]) begin
                rd_data = {22'h0, st_reg.ctrl[i] & `TMCF_CTRL_RW_MASK};
                rd_ok = 1'b1;
            end
            if (idx == IDX_CAP_LO[i]) begin
                rd_data = {24'h0, st_reg.cap[i][7:0]};
                rd_ok = 1'b1;
            end
            // high byte comes from the shared temp
            if (idx == IDX_CAP_HI[i]) begin
                rd_data = {24'h0, st_reg.temp};
                rd_ok = 1'b1;
            end
        end
        if (paddr[1:0] != 2'b00 || (paddr >> 12) != '0) begin
            rd_data = `TMCF_RD_UNMAPPED;
            rd_ok = 1'b0;
        end
    end

    // Next state: bus phase, capture, temp, control and match tracking
    always_comb begin
        st_next = st_reg;
        st_next.force_a = 2'b00;
        st_next.force_b = 2'b00;
        // One wait state, then ready with data or error
        if (access && st_reg.apb == ap_wait) begin
            st_next.apb = ap_done;
            st_next.prdata = pwrite ? 32'h0 : rd_data;
            st_next.pslverr = !rd_ok;
        end else begin
            st_next.apb = ap_wait;
            st_next.prdata = 32'h0;
            st_next.pslverr = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            // remember a match until the next tick
            if (timer_tick[i]) begin
                st_next.pend_a[i] = timer_count[i] == compare_a[i];
                st_next.pend_b[i] = timer_count[i] == compare_b[i];
            end
            // copy the count unless the input is disconnected
            if (cap_evt[i] && !icr_top[i]) begin
                st_next.cap[i] = timer_count[i];
            end
            // low byte write takes the high byte from temp
            if (wr && idx == IDX_CAP_LO[i]) begin
                st_next.cap[i] = {st_reg.temp, pwdata[7:0]};
            end
            // forced strobes only in non-PWM modes, flags untouched
            if (wr && idx == IDX_CTRL[i]) begin
                st_next.ctrl[i] = pwdata[9:0] & `TMCF_CTRL_RW_MASK;
                st_next.force_a[i] = pwdata[`TMCF_CTRL_FOCA] && tmcf_non_pwm(pwdata[3:0]);
                st_next.force_b[i] = pwdata[`TMCF_CTRL_FOCB] && tmcf_non_pwm(pwdata[3:0]);
            end
            // low byte read latches the high byte
            if (rd && idx == IDX_CAP_LO[i]) begin
                st_next.temp = st_reg.cap[i][15:8];
            end
            if (wr && idx == IDX_CAP_HI[i]) begin
                st_next.temp = pwdata[7:0];
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.cap <= {`TMCF_CAP_RST, `TMCF_CAP_RST};
            st_reg.ctrl <= {`TMCF_CTRL_RST, `TMCF_CTRL_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus and strobe outputs straight from the state register
    assign pready = st_reg.apb;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign force_cmp_a = st_reg.force_a;
    assign force_cmp_b = st_reg.force_b;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_wait_a: assert property (
        (access && !pready) |=> pready ##1 !pready)
        else $error("ready not one cycle after wait");
    cap_copy_a: assert property (
        (cap_evt[0] && !icr_top[0] && !(wr && idx == IDX_CAP_LO[0]))
        |=> st_reg.cap[0] == $past(timer_count[0]))
        else $error("capture did not copy count");
    temp_latch_a: assert property (
        (rd && idx == IDX_CAP_LO[1]) |=> st_reg.temp == $past(st_reg.cap[1][15:8]))
        else $error("temp not loaded by low read");
    top_out_a: assert property (
        (wr && idx == IDX_CAP_LO[0]) |=> capture_value[0][7:0] == $past(pwdata[7:0]))
        else $error("written top value not offered");
    cap_hold_a: assert property (
        (icr_top[1] && !(wr && idx == IDX_CAP_LO[1])) |=> $stable(st_reg.cap[1]))
        else $error("capture while used as top");
    cap_flag_a: assert property (
        (cap_evt[1] && !icr_top[1]) |=> flags_rd[1][`TMCF_BIT_CAP])
        else $error("capture flag not set");
    top_flag_a: assert property (
        top_hit[1] |=> flags_rd[1][`TMCF_BIT_CAP])
        else $error("top reach did not set capture flag");
    cmp_next_a: assert property (
        (timer_tick[0] && timer_count[0] == compare_b[0]) ##1 timer_tick[0]
        |=> flags_rd[0][`TMCF_BIT_CMPB])
        else $error("compare flag not set on next tick");
    cmp_early_a: assert property (
        (!flags_rd[1][`TMCF_BIT_CMPA] && !timer_tick[1]) |=> !flags_rd[1][`TMCF_BIT_CMPA])
        else $error("compare flag set without a tick");
    en_write_a: assert property (
        (wr && idx == `TMCF_IDX_EN_B) |=> en_rd[1] == ($past(pwdata[7:0]) & `TMCF_FLAG_MASK))
        else $error("enable write mismatch");
    ovf_flag_a: assert property (
        timer_ovf[1] |=> flags_rd[1][`TMCF_BIT_OVF])
        else $error("overflow flag not set");
    cmpa_irq_a: assert property (
        (en_rd[0][`TMCF_BIT_CMPA] && flags_rd[0][`TMCF_BIT_CMPA] && global_irq_en)
        |=> irq_request[0][1])
        else $error("compare A request missing");
    cmpb_irq_a: assert property (
        !en_rd[1][`TMCF_BIT_CMPB] |=> !irq_request[1][2])
        else $error("compare B request while disabled");
endmodule : tmcf_top
`default_nettype wire

// *** rtl/tmcf_cfg.svh ***
// Register indices, field positions, reset values and counts for the timer capture block
// Assumes an APB slave where each register takes one 32-bit word at four times its index
// Overview of operation
// - A capture event copies the running count into that timer's capture register.
// - Capture register is 16 bits; low byte read latches high byte into shared temp.
// - Capture register value is offered to the counter as top value.
// - Enable and flag bits 7:6 and 4:3 are unused and read as zero.
// - Enable bit 5 with global enable and capture flag requests capture interrupt.
// - Enable bit 2 with global enable and compare-B flag requests its interrupt.
// - Enable bit 1 with global enable and compare-A flag requests its interrupt.
// - Enable bit 0 with global enable and overflow flag requests overflow interrupt.
// - Second timer enable register sits at index 0x71, same layout, resets to zero.
// - Capture flag, bit 5, sets on every capture event of that timer.
// - With capture register as top, capture flag sets when count reaches top.
// - Compare flags bits 2 and 1 set one timer tick after the match.
// - Forced compare strobes never set a compare flag.
// - Overflow flag bit 0 sets on counter overflow, as the sequencer reports it.
// - Each flag clears when its interrupt vector is taken.
// - Writing one to a flag bit clears it; written zeros change nothing.
// - Capture edge select: zero picks falling edge, one picks rising edge.
// - Noise filter moves capture input only after four equal samples.
// - With capture register as top, capture input is disconnected.
`ifndef TMCF_CFG_SVH
`define TMCF_CFG_SVH
`define TMCF_IDX_FLAG_A 10'h036
`define TMCF_IDX_FLAG_B 10'h038
`define TMCF_IDX_EN_A 10'h06f
`define TMCF_IDX_EN_B 10'h071
`define TMCF_IDX_CTRL_A 10'h081
`define TMCF_IDX_CTRL_B 10'h091
`define TMCF_IDX_CAP_LO_A 10'h086
`define TMCF_IDX_CAP_HI_A 10'h087
`define TMCF_IDX_CAP_LO_B 10'h096
`define TMCF_IDX_CAP_HI_B 10'h097
`define TMCF_BIT_OVF 0
`define TMCF_BIT_CMPA 1
`define TMCF_BIT_CMPB 2
`define TMCF_BIT_CAP 5
`define TMCF_FLAG_MASK 8'h27
`define TMCF_FLAG_RST 4'h0
`define TMCF_EN_RST 4'h0
`define TMCF_CAP_RST 16'h0000
`define TMCF_CTRL_RST 10'h000
`define TMCF_CTRL_RW_MASK 10'h07f
`define TMCF_CTRL_ACMP 4
`define TMCF_CTRL_EDGE 5
`define TMCF_CTRL_FILT 6
`define TMCF_CTRL_FOCA 8
`define TMCF_CTRL_FOCB 9
`define TMCF_WGM_NORMAL 4'h0
`define TMCF_WGM_CTC_A 4'h4
`define TMCF_WGM_CTC_CAP 4'hc
`define TMCF_FILT_SAMPLES 4
`define TMCF_RD_UNMAPPED 32'h0000_0000
`endif

// *** rtl/tmcf_pkg.sv ***
// Types for the timer capture and interrupt flag block
// Assumes tmcf_cfg.svh for all numeric constants
`default_nettype none
package tmcf_pkg;
    typedef enum logic {ap_wait = 1'b0, ap_done = 1'b1} tmcf_apb_t;
    typedef struct packed {
        tmcf_apb_t apb;
        logic [31:0] prdata;
        logic pslverr;
        logic [7:0] temp;
        logic [1:0][15:0] cap;
        logic [1:0][9:0] ctrl;
        logic [1:0] pend_a;
        logic [1:0] pend_b;
        logic [1:0] force_a;
        logic [1:0] force_b;
    } tmcf_top_t;
    typedef struct packed {
        logic [1:0] sync_pin;
        logic [1:0] sync_acmp;
        logic [7:0] hist;
        logic filt;
        logic prev;
        logic evt;
    } tmcf_cap_t;
    typedef struct packed {
        logic [3:0] flags;
        logic [3:0] en;
        logic [3:0] irq;
    } tmcf_bank_t;
endpackage : tmcf_pkg
`default_nettype wire

// *** rtl/tmcf_bank_if.sv ***
// Link between the register front end and one timer's flag and enable bank
// Assumes event order [3] capture [2] compare B [1] compare A [0] overflow
`default_nettype none
interface tmcf_bank_if;
    logic [3:0] set;
    logic [3:0] ack;
    logic gie;
    logic wr_flag;
    logic wr_en;
    logic [7:0] wdata;
    logic [7:0] flags_rd;
    logic [7:0] en_rd;
    logic [3:0] irq;
    modport ctl (output set, ack, gie, wr_flag, wr_en, wdata, input flags_rd, en_rd, irq);
    modport bank (input set, ack, gie, wr_flag, wr_en, wdata, output flags_rd, en_rd, irq);
endinterface : tmcf_bank_if
`default_nettype wire

// *** rtl/tmcf_capture_in.sv ***
// Capture input conditioning: synchroniser, noise filter, edge detector
// Assumes asynchronous pin and comparator inputs, controls from the pclk domain
`include "tmcf_cfg.svh"
`default_nettype none
module tmcf_capture_in
    import tmcf_pkg::*;
#(
    parameter int FILT_N = `TMCF_FILT_SAMPLES // Equal samples needed by the filter
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic capture_input_pin, // Asynchronous capture pin
    input wire logic analog_cmp_out, // Asynchronous comparator output
    input wire logic use_analog, // Take comparator instead of pin
    input wire logic capture_edge_select, // One rising, zero falling
    input wire logic capture_noise_filter_en, // Filter on
    input wire logic disable_in, // Capture input disconnected
    output logic capture_evt // One-cycle capture pulse
);
    if (FILT_N < 1 || FILT_N > 8) begin : g_bad_filt
        $error("FILT_N must lie in 1..8");
    end
    tmcf_cap_t st_reg, st_next;
    logic src;

    // Synchronise, filter and detect the chosen edge
    always_comb begin
        st_next = st_reg;
        st_next.sync_pin = {st_reg.sync_pin[0], capture_input_pin};
        st_next.sync_acmp = {st_reg.sync_acmp[0], analog_cmp_out};
        src = use_analog ? st_reg.sync_acmp[1] : st_reg.sync_pin[1];
        st_next.hist = {st_reg.hist[6:0], src};
        if (!capture_noise_filter_en) begin
            st_next.filt = src;
        end else if (st_reg.hist[FILT_N-1:0] == '1) begin
            st_next.filt = 1'b1;
        end else if (st_reg.hist[FILT_N-1:0] == '0) begin
            st_next.filt = 1'b0;
        end
        st_next.prev = st_reg.filt;
        st_next.evt = !disable_in && (capture_edge_select ? (st_reg.filt && !st_reg.prev)
                                                         : (!st_reg.filt && st_reg.prev));
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign capture_evt = st_reg.evt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rise_edge_a: assert property (
        ($rose(st_reg.sync_pin[1]) && !capture_noise_filter_en && !use_analog
            && capture_edge_select && !disable_in)
        ##1 (capture_edge_select && !disable_in) |=> capture_evt)
        else $error("rising pin edge did not capture");
    filter_hold_a: assert property (
        (capture_noise_filter_en && st_reg.hist[FILT_N-1:0] != '0
            && st_reg.hist[FILT_N-1:0] != '1) |=> $stable(st_reg.filt))
        else $error("filter moved without equal samples");
endmodule : tmcf_capture_in
`default_nettype wire

// *** rtl/tmcf_flag_bank.sv ***
// Flag and enable bank of one timer with interrupt request gating
// Assumes set and clear strobes from the pclk domain
`include "tmcf_cfg.svh"
`default_nettype none
module tmcf_flag_bank
    import tmcf_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Asynchronous reset, active low
    tmcf_bank_if.bank bus // Strobes in, read values and requests out
);
    localparam int POS [4] = '{`TMCF_BIT_OVF, `TMCF_BIT_CMPA, `TMCF_BIT_CMPB, `TMCF_BIT_CAP};
    tmcf_bank_t st_reg, st_next;

    // Update enables, flags and requests
    always_comb begin
        st_next = st_reg;
        for (int k = 0; k < 4; k++) begin
            if (bus.wr_en) begin
                st_next.en[k] = bus.wdata[POS[k]];
            end
            // vector taken or one written clears
            if ((bus.wr_flag && bus.wdata[POS[k]]) || bus.ack[k]) begin
                st_next.flags[k] = 1'b0;
            end
            if (bus.set[k]) begin
                st_next.flags[k] = 1'b1;
            end
            st_next.irq[k] = st_reg.en[k] && st_reg.flags[k] && bus.gie;
        end
    end

    always_comb begin
        bus.flags_rd = 8'h00;
        bus.en_rd = 8'h00;
        for (int k = 0; k < 4; k++) begin
            bus.flags_rd[POS[k]] = st_reg.flags[k];
            bus.en_rd[POS[k]] = st_reg.en[k];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= {`TMCF_FLAG_RST, `TMCF_EN_RST, 4'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.irq = st_reg.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cap_irq_a: assert property (
        (st_reg.en[3] && st_reg.flags[3] && bus.gie) |=> bus.irq[3])
        else $error("capture request missing");
    ovf_gate_a: assert property (
        !bus.gie |=> !bus.irq[0])
        else $error("overflow request without global enable");
    set_wins_a: assert property (
        (bus.set[1] && bus.wr_flag && bus.wdata[1]) |=> bus.flags_rd[1])
        else $error("clear beat a set");
    clear_one_a: assert property (
        (bus.wr_flag && bus.wdata[2] && !bus.set[2]) |=> !bus.flags_rd[2])
        else $error("write one did not clear");
    vector_clr_a: assert property (
        (bus.ack[0] && !bus.set[0]) |=> !bus.flags_rd[0])
        else $error("vector did not clear flag");
    reserved_zero_a: assert property (
        ((bus.flags_rd | bus.en_rd) & ~`TMCF_FLAG_MASK) == 8'h00)
        else $error("reserved bit not zero");
endmodule : tmcf_flag_bank
`default_nettype wire

// *** testbench/tmcf_cnt_model.sv ***
// Counter model for the capture block: tick, count and overflow
// Assumes a free pclk and a run level from the bench
`default_nettype none
module tmcf_cnt_model (
    input wire logic pclk, // System clock
    input wire logic presetn, // Reset, active low
    input wire logic run, // Count enable
    output logic [15:0] count, // Running count
    output logic tick, // Timer clock pulse
    output logic ovf // Wrap pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start near the top so that a wrap comes early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'hff00;
        end else if (run) begin
            count <= count + 16'h0001;
        end
    end
    // One tick per cycle while running
    assign tick = run;
    assign ovf = run && count == 16'hffff;
endmodule : tmcf_cnt_model
`default_nettype wire

// *** testbench/timer16_capture_irq_flags_tb_top.sv ***
// Self-checking bench for the timer capture, flag and request block
// Assumes the counter model as far side and APB as the register bus
`default_nettype none
module timer16_capture_irq_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, gie, tick, ovf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, w;
    logic [15:0] count;
    logic [1:0][15:0] capv;
    logic [1:0] pin, foca, focb;
    logic [1:0][3:0] ack, irq, wmode;
    logic [33:0] exq[$];
    logic [33:0] e;
    int num_errors, n_tests, seed;
    tmcf_cnt_model u_cnt (.pclk(pclk), .presetn(presetn), .run(run), .count(count),
        .tick(tick), .ovf(ovf));
    tmcf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_count({count, count}), .timer_tick({tick, tick}),
        .compare_a({16'h8000, 16'h0005}), .compare_b({16'h8000, 16'hff80}),
        .timer_ovf({ovf, ovf}), .capture_input_pin(pin), .analog_cmp_out(1'b0),
        .global_irq_en(gie), .irq_vector_ack(ack), .irq_request(irq), .capture_value(capv),
        .waveform_mode_field(wmode), .force_cmp_a(foca), .force_cmp_b(focb));
    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Bus request held until pready, expected answer noted first
    task automatic xfer(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                        input logic [33:0] x);
        int n;
        exq.push_back(x);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0, {2'b00, x});
    endtask : rd
    // Answer monitor: error flag and read data against the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = exq.pop_front();
            cmp({31'h0, pslverr}, {31'h0, e[32]});
            cmp(prdata, e[33] ? 32'h0 : e[31:0]);
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, run, gie, pin, ack, paddr, pwdata} = 60'h0;
        num_errors = 0;
        n_tests = 0;
        seed = 32'hd4262383;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h1c4, 32'h0);
        w = $random(seed);
        xfer(1'b1, 12'h1c4, w, 34'h200000000);
        rd(12'h1c4, w & 32'h27);
        xfer(1'b0, 12'h000, 32'h0, 34'h100000000);
        run <= 1'b1;
        repeat (300) @(posedge pclk);
        run <= 1'b0;
        xfer(1'b1, 12'h204, 32'h60, 34'h200000000);
        pin <= 2'b11;
        repeat (12) @(posedge pclk);
        pin <= 2'b01;
        repeat (12) @(posedge pclk);
        xfer(1'b1, 12'h21c, 32'ha5, 34'h200000000);
        rd(12'h218, 32'h2c);
        rd(12'h21c, 32'h0);
        rd(12'h258, 32'h2c);
        cmp({capv[1], capv[0]}, 32'h002c002c);
        rd(12'h0d8, 32'h27);
        rd(12'h0e0, 32'h21);
        xfer(1'b1, 12'h0d8, 32'h05, 34'h200000000);
        rd(12'h0d8, 32'h22);
        xfer(1'b1, 12'h1bc, 32'h21, 34'h200000000);
        gie <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp({28'h0, irq[0]}, 32'h8);
        cmp({28'h0, irq[1]}, {28'h0, w[5], 2'b00, w[0]});
        gie <= 1'b0;
        repeat (3) @(posedge pclk);
        cmp({24'h0, irq}, 32'h0);
        ack <= 8'h18;
        @(posedge pclk);
        ack <= 8'h00;
        rd(12'h0d8, 32'h02);
        xfer(1'b1, 12'h0d8, 32'h02, 34'h200000000);
        xfer(1'b1, 12'h204, 32'h120, 34'h200000000);
        cmp({28'h0, focb, foca}, 32'h1);
        rd(12'h0d8, 32'h0);
        // Timer b with capture register as top: pin ignored, flag on top reach
        xfer(1'b1, 12'h244, 32'h0c, 34'h200000000);
        xfer(1'b1, 12'h25c, 32'h00, 34'h200000000);
        xfer(1'b1, 12'h258, 32'h30, 34'h200000000);
        cmp({capv[1], 12'h0, wmode[1]}, 32'h0030000c);
        xfer(1'b1, 12'h0e0, 32'h21, 34'h200000000);
        pin <= 2'b11;
        run <= 1'b1;
        repeat (10) @(posedge pclk);
        run <= 1'b0;
        pin <= 2'b01;
        repeat (12) @(posedge pclk);
        rd(12'h258, 32'h30);
        rd(12'h0e0, 32'h20);
        end_sim();
    end
endmodule : timer16_capture_irq_flags_tb_top
`default_nettype wire
